//--- dv/jct_config_tap_checker.sv
// Purpose: Port-level assertions for the configuration test port
// Assumes: One core clock domain, pins synchronised inside
// Notes:   Bound to the top module after the checker
`timescale 1ns/1ps
module jct_config_tap_checker #(
    parameter            CFG_W   = 109,
    parameter            ID_W    = 32,
    parameter [ID_W-1:0] ID_CODE = 32'h0000_0000
) (
    input wire             core_clk_i,
    input wire             rst_n_i,
    input wire             tck_i,
    input wire             tms_i,
    input wire             tdi_i,
    input wire             trst_n_i,
    input wire             tdo_o,
    input wire             tdo_oe_o,
    input wire [CFG_W-1:0] cells_cfg_i,
    input wire             cells_lock_i,
    input wire             cells_busy_i,
    input wire             prog_start_o,
    input wire             erase_start_o,
    input wire             readback_start_o,
    input wire             calib_start_o,
    input wire [CFG_W-1:0] prog_data_o,
    input wire             lock_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_lock_reset: assert property ($rose(rst_n_i) |-> lock_o)
        else $error("lock mirror low after reset");
    a_lock_clear: assert property ($fell(lock_o) |-> erase_start_o || $past(erase_start_o))
        else $error("lock mirror cleared without erase");
    a_tdo_fall: assert property ($changed(tdo_o) |-> !tck_i)
        else $error("serial out changed while test clock high");
    a_oe_fall: assert property ($rose(tdo_oe_o) |-> !tck_i)
        else $error("out enable rose while test clock high");
    a_trst_oe: assert property (!trst_n_i [*5] |=> !tdo_oe_o)
        else $error("out enable held during test reset");
    a_prog_pulse: assert property (prog_start_o |=> !prog_start_o)
        else $error("program start longer than one cycle");
    a_calib_pulse: assert property (calib_start_o |=> !calib_start_o)
        else $error("calibration start longer than one cycle");
    a_start_alone: assert property (prog_start_o |-> !(erase_start_o || readback_start_o || calib_start_o))
        else $error("two operations started together");
    a_pdata_hold: assert property ($changed(prog_data_o) |-> prog_start_o || $past(prog_start_o))
        else $error("program data changed without program start");
    a_busy_block: assert property (cells_busy_i && $past(cells_busy_i) |-> !prog_start_o && !calib_start_o)
        else $error("deferred start while cells busy");
endmodule // jct_config_tap_checker

bind jct_config_tap jct_config_tap_checker #(.CFG_W(CFG_W), .ID_W(ID_W), .ID_CODE(ID_CODE)) jct_config_tap_checker_i (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i),
    .trst_n_i(trst_n_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .cells_cfg_i(cells_cfg_i),
    .cells_lock_i(cells_lock_i), .cells_busy_i(cells_busy_i), .prog_start_o(prog_start_o),
    .erase_start_o(erase_start_o), .readback_start_o(readback_start_o),
    .calib_start_o(calib_start_o), .prog_data_o(prog_data_o), .lock_o(lock_o));

//--- dv/jct_host_model.sv
// Purpose: Host controller model for the serial test port
// Assumes: Test clock period of 25 core cycles, 125 ns
// Notes:   Test clock stands low between frames; released TDO reads high
`timescale 1ns/1ps
module jct_host_model (
    input  wire clk_i,
    input  wire tdo_i,
    input  wire oe_i,
    output reg  tck_o    = 1'b0,
    output reg  tms_o    = 1'b1,
    output reg  tdi_o    = 1'b0,
    output reg  trst_n_o = 1'b1
);
    wire  tdo_w = oe_i ? tdo_i : 1'b1;
    logic bit_q;

    // One test clock period; TDO taken just before the rise
    task automatic step(input logic ms, input logic di);
        tms_o <= ms;
        tdi_o <= di;
        repeat (6) @(posedge clk_i);
        bit_q = tdo_w;
        tck_o <= 1'b1;
        repeat (12) @(posedge clk_i);
        tck_o <= 1'b0;
        repeat (7) @(posedge clk_i);
    endtask

    task automatic walk(input logic [7:0] ms, input int n);
        for (int i = 0; i < n; i++)
            step(ms[i], 1'b0);
    endtask

    // From idle: capture, shift n bits LSB first, stop in update
    task automatic scan(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout);
        dout = '0;
        walk(ir ? 8'h03 : 8'h01, ir ? 2 : 1);
        walk(8'h00, 2);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i]);
            dout[i] = bit_q;
        end
        step(1'b1, 1'b0);
    endtask

    task automatic test_reset();
        trst_n_o <= 1'b0;
        repeat (8) @(posedge clk_i);
        trst_n_o <= 1'b1;
        repeat (8) @(posedge clk_i);
    endtask
endmodule // jct_host_model

//--- dv/testbench.sv
// Purpose: Self-checking bench for the configuration test port
// Assumes: Host model drives the test pins, cells modelled here
// Notes:   Scenarios run in order from power-on reset
`timescale 1ns/1ps
`include "jct_map.vh"
module testbench;
    localparam        CW  = `JCT_CFG_W;
    localparam [31:0] IDV = 32'h1234_5671; // Arbitrary value
    logic          core_clk;
    logic          rst_n   = 1'b0;
    logic          busy    = 1'b0;
    logic          lock_in = 1'b0;
    logic [CW-1:0] cfg_in  = CW'({4{32'hC3A5_0F96}});
    logic [127:0]  dout;
    wire           tck, tms, tdi, trst_n, tdo, oe, prog, erase, rdb, cal, lock;
    wire  [CW-1:0] pdata;
    int            errors, n_checks, cyc, n_prog, n_erase, n_rdb, n_cal;

    jct_config_tap #(.ID_CODE(IDV)) jct_config_tap_i (
        .core_clk_i(core_clk), .rst_n_i(rst_n), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n),
        .tdo_o(tdo), .tdo_oe_o(oe), .cells_cfg_i(cfg_in), .cells_lock_i(lock_in), .cells_busy_i(busy),
        .prog_start_o(prog), .erase_start_o(erase), .readback_start_o(rdb), .calib_start_o(cal),
        .prog_data_o(pdata), .lock_o(lock));
    jct_host_model jct_host_model_i (
        .clk_i(core_clk), .tdo_i(tdo), .oe_i(oe), .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // ----------------------------------------
    // Pulse counters and run limit
    // ----------------------------------------
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (prog === 1'b1) n_prog <= n_prog + 1;
        if (erase === 1'b1) n_erase <= n_erase + 1;
        if (rdb === 1'b1) n_rdb <= n_rdb + 1;
        if (cal === 1'b1) n_cal <= n_cal + 1;
        if (cyc == 60000) begin
            errors++;
            complete_run();
        end
    end

    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("errors=%0d checks=%0d", errors, n_checks);
        if (errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic ir_go(input logic [4:0] code);
        jct_host_model_i.scan(1'b1, 5, 128'(code), dout);
        jct_host_model_i.step(1'b0, 1'b0);
    endtask

    task automatic dr_go(input int n, input logic [127:0] din);
        jct_host_model_i.scan(1'b0, n, din, dout);
        jct_host_model_i.step(1'b0, 1'b0);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_id();
        jct_host_model_i.step(1'b0, 1'b0);
        dr_go(32, 128'h0);
        chk(dout[31:0], IDV);
        chk(128'(n_prog + n_erase + n_rdb + n_cal), 128'h0);
        jct_host_model_i.scan(1'b1, 5, 128'h1F, dout);
        chk(dout[4:0], 5'h0D);
        jct_host_model_i.step(1'b0, 1'b0);
    endtask

    task automatic t_bypass();
        logic [19:0] codes;
        codes = {5'h00, 5'h1E, 5'h1F, 5'h05};
        for (int i = 0; i < 4; i++) begin
            ir_go(codes[5*i +: 5]);
            dr_go(8, 128'hA5);
            chk(dout[7:0], 8'h4A);
        end
    endtask

    task automatic t_tms_rst();
        ir_go(5'h1F);
        jct_host_model_i.walk(8'h01, 3);
        jct_host_model_i.walk(8'h1F, 5);
        jct_host_model_i.step(1'b0, 1'b0);
        dr_go(32, 128'h0);
        chk(dout[31:0], IDV);
    endtask

    task automatic t_trst();
        ir_go(5'h1F);
        jct_host_model_i.walk(8'h01, 3);
        chk(oe, 1'b1);
        jct_host_model_i.test_reset();
        chk(oe, 1'b0);
        jct_host_model_i.step(1'b0, 1'b0);
        dr_go(32, 128'h0);
        chk(dout[31:0], IDV);
    endtask

    task automatic t_pause();
        ir_go(5'h0D);
        jct_host_model_i.walk(8'h01, 3);
        jct_host_model_i.step(1'b1, 1'b0);
        chk(jct_host_model_i.bit_q, IDV[0]);
        jct_host_model_i.walk(8'h00, 2);
        chk(oe, 1'b0);
        jct_host_model_i.walk(8'h01, 2);
        jct_host_model_i.step(1'b1, 1'b0);
        chk(jct_host_model_i.bit_q, IDV[1]);
        jct_host_model_i.walk(8'h01, 2);
    endtask

    task automatic rb(input logic [CW-1:0] exp);
        int n0;
        n0 = n_rdb;
        ir_go(5'h03);
        chk(128'(n_rdb - n0), 128'h1);
        ir_go(5'h01);
        dr_go(CW, 128'h0);
        chk(dout[CW-1:0], exp);
    endtask

    task automatic t_lock();
        chk(lock, 1'b1);
        rb('0);
        ir_go(5'h02);
        chk(128'(n_erase), 128'h1);
        chk(lock, 1'b0);
        rb(cfg_in);
        ir_go(5'h03);
        lock_in <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk(lock, 1'b1);
        ir_go(5'h01);
        dr_go(CW, 128'h0);
        chk(dout[CW-1:0], 128'h0);
        rb('0);
    endtask

    task automatic t_program();
        logic [CW-1:0] pat;
        pat = CW'({4{32'h5A3C_96E1}});
        ir_go(5'h01);
        dr_go(CW, 128'(pat));
        busy <= 1'b1;
        ir_go(5'h04);
        chk(128'(n_prog), 128'h0);
        busy <= 1'b0;
        jct_host_model_i.scan(1'b1, 5, 128'h04, dout);
        chk(128'(n_prog), 128'h0);
        jct_host_model_i.step(1'b0, 1'b0);
        chk(128'(n_prog), 128'h1);
        chk(128'(pdata), 128'(pat));
        ir_go(5'h10);
        chk(128'(n_cal), 128'h1);
    endtask

    initial begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        t_id();
        t_bypass();
        t_tms_rst();
        t_trst();
        t_pause();
        t_lock();
        t_program();
        complete_run();
    end
endmodule // testbench

//--- hw/jct_config_tap.v
// Purpose: Serial test port for configuration program and readback
// Assumes: TCK slower than a quarter of core_clk_i; cells modelled by ports
// Notes:   No boundary-scan cells; scan-related codes fall back to bypass
`timescale 1ns/1ps
`include "jct_map.vh"

module jct_config_tap #(
    parameter            CFG_W   = `JCT_CFG_W,
    parameter            ID_W    = `JCT_ID_W,
    parameter [ID_W-1:0] ID_CODE = 32'h1234_5671 // Arbitrary value
) (
    input  wire             core_clk_i,
    input  wire             rst_n_i,
    input  wire             tck_i,
    input  wire             tms_i,
    input  wire             tdi_i,
    input  wire             trst_n_i,
    output wire             tdo_o,
    output wire             tdo_oe_o,
    input  wire [CFG_W-1:0] cells_cfg_i,
    input  wire             cells_lock_i,
    input  wire             cells_busy_i,
    output wire             prog_start_o,
    output wire             erase_start_o,
    output wire             readback_start_o,
    output wire             calib_start_o,
    output wire [CFG_W-1:0] prog_data_o,
    output wire             lock_o
);

    // ----------------------------------------
    // Pin sampling
    // ----------------------------------------
    wire [3:0] pin_lvl;
    wire [3:0] pin_rise;
    wire [3:0] pin_fall;

    jct_pin_sync #(
        .W (4)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .pin_i      ({trst_n_i, tdi_i, tms_i, tck_i}),
        .rst_val_i  (4'h0),
        .lvl_o      (pin_lvl),
        .rise_o     (pin_rise),
        .fall_o     (pin_fall)
    );

    // Pins cross two flops before any edge or level is used
    wire tck_rise = pin_rise[0];
    wire tck_fall = pin_fall[0];
    wire tms_s    = pin_lvl[1];
    wire tdi_s    = pin_lvl[2];
    wire trst_n_s = pin_lvl[3];

    // ----------------------------------------
    // Controller
    // ----------------------------------------
    wire [3:0] state;

    // Advances once per synchronised rising test clock
    jct_tap_fsm u_fsm (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .trst_n_i   (trst_n_s),
        .adv_i      (tck_rise),
        .tms_i      (tms_s),
        .state_o    (state)
    );

    // Strobes other than in_reset last one core cycle per rising test clock
    wire in_reset = (state == `JCT_ST_RESET);
    wire cap_dr   = tck_rise && (state == `JCT_ST_CAP_DR);
    wire sh_dr    = tck_rise && (state == `JCT_ST_SH_DR);
    wire cap_ir   = tck_rise && (state == `JCT_ST_CAP_IR);
    wire sh_ir    = tck_rise && (state == `JCT_ST_SH_IR);
    wire upd_ir   = tck_rise && (state == `JCT_ST_UPD_IR);
    wire upd_dr   = tck_rise && (state == `JCT_ST_UPD_DR);
    // Idle is entered only from reset or an update state
    wire to_idle  = tck_rise && !tms_s && (state != `JCT_ST_IDLE) &&
                    (state == `JCT_ST_UPD_IR || state == `JCT_ST_UPD_DR ||
                     state == `JCT_ST_RESET);

    // ----------------------------------------
    // Instruction register
    // ----------------------------------------
    // Shift stage and active code kept apart until update
    reg [`JCT_IR_W-1:0] ir_sh_ff;
    reg [`JCT_IR_W-1:0] ir_ff;
    reg                 pend_ff;

    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ir_sh_ff <= `JCT_OP_IDREAD;
            ir_ff    <= `JCT_OP_IDREAD;
        end else if (in_reset) begin
            ir_ff    <= `JCT_OP_IDREAD;
            ir_sh_ff <= `JCT_OP_IDREAD;
        end else if (cap_ir) begin
            ir_sh_ff <= `JCT_OP_IDREAD;
        end else if (sh_ir) begin
            ir_sh_ff <= {tdi_s, ir_sh_ff[`JCT_IR_W-1:1]};
        end else if (upd_ir) begin
            ir_ff    <= ir_sh_ff;
        end
    end

    // Deferred operations armed at update, fired on the next idle entry if cells are not busy, else dropped
    // Update edge may itself enter idle, so look through to the new code
    wire [`JCT_IR_W-1:0] ir_eff   = upd_ir ? ir_sh_ff : ir_ff;
    wire                 armed    = upd_ir || pend_ff;
    wire                 deferred = (ir_eff == `JCT_OP_PROGRAM) || (ir_eff == `JCT_OP_ERASE) ||
                                    (ir_eff == `JCT_OP_CALIB);
    wire                 fire     = to_idle && armed && deferred && !cells_busy_i;
    wire                 prog_go  = fire && (ir_eff == `JCT_OP_PROGRAM);
    wire                 erase_go = fire && (ir_eff == `JCT_OP_ERASE);
    wire                 cal_go   = fire && (ir_eff == `JCT_OP_CALIB);

    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend_ff <= 1'b0;
        end else if (in_reset) begin
            pend_ff <= 1'b0;
        end else if (to_idle) begin
            pend_ff <= 1'b0;
        end else if (upd_ir) begin
            pend_ff <= 1'b1;
        end
    end

    // ----------------------------------------
    // Data register select
    // ----------------------------------------
    wire sel_cfg = (ir_ff == `JCT_OP_SEL_CFG) || (ir_ff == `JCT_OP_PROGRAM) ||
                   (ir_ff == `JCT_OP_READBACK);
    wire sel_id  = (ir_ff == `JCT_OP_IDREAD);
    // Unlisted codes, boundary-scan ones included, fall to bypass
    wire sel_byp = !sel_cfg && !sel_id;

    // ----------------------------------------
    // Data registers
    // ----------------------------------------
    reg [CFG_W-1:0] cfg_sh_ff;
    reg [CFG_W-1:0] cfg_hold_ff;
    reg [ID_W-1:0]  id_sh_ff;
    reg             byp_ff;
    reg             lock_ff;
    reg             rb_pend_ff;

    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_sh_ff <= {CFG_W{1'b0}};
        end else if (cap_dr && sel_cfg) begin
            // Locked parts capture zeros even from an older snapshot
            cfg_sh_ff <= lock_ff ? {CFG_W{1'b0}} : cfg_hold_ff;
        end else if (sh_dr && sel_cfg) begin
            cfg_sh_ff <= {tdi_s, cfg_sh_ff[CFG_W-1:1]};
        end
    end

    // Readback snapshot; blanked while locked
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_hold_ff <= {CFG_W{1'b0}};
        end else if (rb_pend_ff) begin
            cfg_hold_ff <= lock_ff ? {CFG_W{1'b0}} : cells_cfg_i;
        end else if (upd_dr && sel_cfg) begin
            cfg_hold_ff <= lock_ff ? {CFG_W{1'b0}} : cfg_sh_ff;
        end
    end

    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rb_pend_ff <= 1'b0;
        end else begin
            // Cell snapshot follows one cycle after update
            rb_pend_ff <= upd_ir && (ir_sh_ff == `JCT_OP_READBACK);
        end
    end

    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            id_sh_ff <= {ID_W{1'b0}};
        end else if (cap_dr && sel_id) begin
            // Fixed word, loaded only when selected
            id_sh_ff <= ID_CODE;
        end else if (sh_dr && sel_id) begin
            id_sh_ff <= {tdi_s, id_sh_ff[ID_W-1:1]};
        end
    end

    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            byp_ff <= 1'b0;
        end else if (cap_dr && sel_byp) begin
            // Known zero first, as a chained scan expects
            byp_ff <= 1'b0;
        end else if (sh_dr && sel_byp) begin
            byp_ff <= tdi_s;
        end
    end

    // ----------------------------------------
    // Security lock mirror
    // ----------------------------------------
    // Follows the cells; only an erase lets it clear
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lock_ff <= 1'b1;
        end else if (cells_lock_i) begin
            lock_ff <= 1'b1;
        end else if (erase_go) begin
            lock_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // Deferred operation start
    // ----------------------------------------
    // One-cycle start pulses; pattern held until the next program
    reg             prog_ff;
    reg             erase_ff;
    reg             cal_ff;
    reg [CFG_W-1:0] prog_data_ff;

    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prog_ff      <= 1'b0;
            erase_ff     <= 1'b0;
            cal_ff       <= 1'b0;
            prog_data_ff <= {CFG_W{1'b0}};
        end else begin
            prog_ff  <= prog_go;
            erase_ff <= erase_go;
            cal_ff   <= cal_go;
            if (prog_go) begin
                prog_data_ff <= cfg_sh_ff;
            end
        end
    end

    assign prog_start_o     = prog_ff;
    assign erase_start_o    = erase_ff;
    assign calib_start_o    = cal_ff;
    assign readback_start_o = rb_pend_ff;
    assign prog_data_o      = prog_data_ff;
    assign lock_o           = lock_ff;

    // ----------------------------------------
    // Serial output
    // ----------------------------------------
    reg tdo_ff;
    reg oe_ff;

    wire sh_ir_st = (state == `JCT_ST_SH_IR);
    wire sh_dr_st = (state == `JCT_ST_SH_DR);
    // Moves after the falling test clock; released outside shift states
    // so that chained parts never drive against each other
    wire dr_bit   = sel_cfg ? cfg_sh_ff[0] : (sel_id ? id_sh_ff[0] : byp_ff);

    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tdo_ff <= 1'b0;
            oe_ff  <= 1'b0;
        end else if (!trst_n_s) begin
            oe_ff  <= 1'b0;
        end else if (tck_fall) begin
            tdo_ff <= sh_ir_st ? ir_sh_ff[0] : dr_bit;
            oe_ff  <= sh_ir_st || sh_dr_st;
        end
    end

    assign tdo_o    = tdo_ff;
    assign tdo_oe_o = oe_ff;

endmodule // jct_config_tap

//--- hw/jct_pin_sync.v
// Purpose: Two-stage synchroniser and edge finder for the test pins
// Assumes: Pins are asynchronous to core_clk_i
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps

module jct_pin_sync #(
    parameter W = 4
) (
    input  wire         core_clk_i,
    input  wire         rst_n_i,
    input  wire [W-1:0] pin_i,
    input  wire [W-1:0] rst_val_i,
    output wire [W-1:0] lvl_o,
    output wire [W-1:0] rise_o,
    output wire [W-1:0] fall_o
);

    reg [W-1:0] meta_ff;
    reg [W-1:0] sync_ff;
    reg [W-1:0] prev_ff;

    // ----------------------------------------
    // Synchroniser chain
    // ----------------------------------------
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_ff <= {W{1'b0}};
            sync_ff <= {W{1'b0}};
            prev_ff <= {W{1'b0}};
        end else begin
            meta_ff <= pin_i;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign lvl_o  = sync_ff;
    assign rise_o = sync_ff & ~prev_ff & ~rst_val_i;
    assign fall_o = ~sync_ff & prev_ff;

endmodule // jct_pin_sync

//--- hw/jct_tap_fsm.v
// Purpose: Sixteen-state test access port controller
// Assumes: Advance strobe is one core cycle per rising TCK
// Notes:   Test reset forces the reset state at once
`timescale 1ns/1ps
`include "jct_map.vh"

module jct_tap_fsm (
    input  wire       core_clk_i,
    input  wire       rst_n_i,
    input  wire       trst_n_i,
    input  wire       adv_i,
    input  wire       tms_i,
    output wire [3:0] state_o
);

    reg [3:0] state_ff;
    reg [3:0] nxt_state;

    always @* begin
        case (state_ff)
            `JCT_ST_RESET:  nxt_state = tms_i ? `JCT_ST_RESET  : `JCT_ST_IDLE;
            `JCT_ST_IDLE:   nxt_state = tms_i ? `JCT_ST_SEL_DR : `JCT_ST_IDLE;
            `JCT_ST_SEL_DR: nxt_state = tms_i ? `JCT_ST_SEL_IR : `JCT_ST_CAP_DR;
            `JCT_ST_CAP_DR: nxt_state = tms_i ? `JCT_ST_EX1_DR : `JCT_ST_SH_DR;
            `JCT_ST_SH_DR:  nxt_state = tms_i ? `JCT_ST_EX1_DR : `JCT_ST_SH_DR;
            `JCT_ST_EX1_DR: nxt_state = tms_i ? `JCT_ST_UPD_DR : `JCT_ST_PAU_DR;
            `JCT_ST_PAU_DR: nxt_state = tms_i ? `JCT_ST_EX2_DR : `JCT_ST_PAU_DR;
            `JCT_ST_EX2_DR: nxt_state = tms_i ? `JCT_ST_UPD_DR : `JCT_ST_SH_DR;
            `JCT_ST_UPD_DR: nxt_state = tms_i ? `JCT_ST_SEL_DR : `JCT_ST_IDLE;
            `JCT_ST_SEL_IR: nxt_state = tms_i ? `JCT_ST_RESET  : `JCT_ST_CAP_IR;
            `JCT_ST_CAP_IR: nxt_state = tms_i ? `JCT_ST_EX1_IR : `JCT_ST_SH_IR;
            `JCT_ST_SH_IR:  nxt_state = tms_i ? `JCT_ST_EX1_IR : `JCT_ST_SH_IR;
            `JCT_ST_EX1_IR: nxt_state = tms_i ? `JCT_ST_UPD_IR : `JCT_ST_PAU_IR;
            `JCT_ST_PAU_IR: nxt_state = tms_i ? `JCT_ST_EX2_IR : `JCT_ST_PAU_IR;
            `JCT_ST_EX2_IR: nxt_state = tms_i ? `JCT_ST_UPD_IR : `JCT_ST_SH_IR;
            `JCT_ST_UPD_IR: nxt_state = tms_i ? `JCT_ST_SEL_DR : `JCT_ST_IDLE;
            default:        nxt_state = `JCT_ST_RESET;
        endcase
    end

    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= `JCT_ST_RESET;
        end else if (!trst_n_i) begin
            state_ff <= `JCT_ST_RESET;
        end else if (adv_i) begin
            state_ff <= nxt_state;
        end
    end

    assign state_o = trst_n_i ? state_ff : `JCT_ST_RESET;

endmodule // jct_tap_fsm

//--- shared/jct_map.vh
// Purpose: Constants for the configuration test access port
// Assumes: Five-bit instructions, TCK sampled by core clock
// Notes:   Included by jct_config_tap, jct_tap_fsm and the testbench; jct_pin_sync does not include it
`ifndef JCT_MAP_VH
`define JCT_MAP_VH

// ----------------------------------------
// Instruction codes
// ----------------------------------------
`define JCT_IR_W            5
`define JCT_OP_EXTEST       5'h00
`define JCT_OP_SEL_CFG      5'h01
`define JCT_OP_ERASE        5'h02
`define JCT_OP_READBACK     5'h03
`define JCT_OP_PROGRAM      5'h04
`define JCT_OP_IDREAD       5'h0D
`define JCT_OP_CALIB        5'h10
`define JCT_OP_SAMPLE       5'h1E
`define JCT_OP_BYPASS       5'h1F

// ----------------------------------------
// Register lengths
// ----------------------------------------
`define JCT_CFG_W           109
`define JCT_ID_W            32

// ----------------------------------------
// Controller states
// ----------------------------------------
`define JCT_ST_RESET        4'h0
`define JCT_ST_IDLE         4'h1
`define JCT_ST_SEL_DR       4'h2
`define JCT_ST_CAP_DR       4'h3
`define JCT_ST_SH_DR        4'h4
`define JCT_ST_EX1_DR       4'h5
`define JCT_ST_PAU_DR       4'h6
`define JCT_ST_EX2_DR       4'h7
`define JCT_ST_UPD_DR       4'h8
`define JCT_ST_SEL_IR       4'h9
`define JCT_ST_CAP_IR       4'hA
`define JCT_ST_SH_IR        4'hB
`define JCT_ST_EX1_IR       4'hC
`define JCT_ST_PAU_IR       4'hD
`define JCT_ST_EX2_IR       4'hE
`define JCT_ST_UPD_IR       4'hF

`endif
